// ### design/desc_pkg.sv
// Descriptor field layout, register map and engine states for the descriptor engine.
// Assumes a single 20 MHz clock domain and AXI4-Lite register access.
package desc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] DW0_LO_OFFSET = 8'h00;
  localparam logic [7:0] DW0_HI_OFFSET = 8'h04;
  localparam logic [7:0] DW1_HI_OFFSET = 8'h08;
  localparam logic [7:0] DW2_LO_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  // Writable bit masks; reserved bits stay zero
  localparam logic [31:0] DW0_LO_MASK = 32'hFFFF_FFF9;
  localparam logic [31:0] DW0_HI_MASK = 32'h03F8_7FFF;
  localparam logic [31:0] DW1_HI_MASK = 32'h0000_7FFF;
  localparam logic [31:0] DW2_LO_MASK = 32'h1EFF_FF00;
  localparam logic [31:0] RESET_WORD  = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // First double word, low half
  localparam int EP0_BIT      = 31;
  localparam int MULT_LSB     = 29;
  localparam int MAXPKT_LSB   = 18;
  localparam int BYTECNT_LSB  = 3;
  localparam int VALID_BIT    = 0;
  // First double word, high half (bit 32 maps to 0)
  localparam int DONE_LSB     = 0;
  localparam int NAK_RETRY_COUNTER_LSB   = 19;
  localparam int CERR_LSB     = 23;
  localparam int TOGGLE_BIT   = 25;
  // Second double word, high half
  localparam int EPHI_LSB     = 0;
  localparam int DEVADDR_LSB  = 3;
  localparam int TOKEN_LSB    = 10;
  localparam int EPTYPE_LSB   = 12;
  localparam int SPLIT_BIT    = 14;
  // Third double word, low half
  localparam int POINTER_LSB  = 8;
  localparam int RELOAD_LSB   = 25;

  localparam logic [10:0] BULK_MAX_PACKET = 11'h200;
  localparam logic [16:0] RAM_CPU_BASE    = 17'h00400;
  localparam int          RAM_WORD_SHIFT  = 3;

  // Token encodings
  localparam logic [1:0] TOKEN_OUT   = 2'h0;
  localparam logic [1:0] TOKEN_IN    = 2'h1;
  localparam logic [1:0] TOKEN_SETUP = 2'h2;
  localparam logic [1:0] TOKEN_PING  = 2'h3;

  // Link results
  localparam logic [1:0] RES_ACK   = 2'h0;
  localparam logic [1:0] RES_NAK   = 2'h1;
  localparam logic [1:0] RES_ERR   = 2'h2;
  localparam logic [1:0] RES_FATAL = 2'h3;

  ////////////////////////////////////////////////////////////////////////////////
  // Isochronous descriptor layout: eight double words, bit positions within each
  localparam int ISO_DWORDS        = 8;
  localparam int ISO_POINTER_LSB   = 8;
  localparam int ISO_POINTER_W     = 16;
  localparam int ISO_UFRAME_LSB    = 0;
  localparam int ISO_ACTIVE_LSB    = 0;
  localparam int ISO_STATUS_LSB    = 8;
  localparam int ISO_STATUS_W      = 3;
  localparam int ISO_IN_COUNT_W    = 12;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_WAIT} engine_state_t;

endpackage

// ### design/desc_field_decode.sv
// Combinational decode of the stored descriptor words into execution fields.
// Assumes the words come straight from the register file.
`timescale 1ns/100ps
module desc_field_decode
(
  input  wire logic [31:0] dw0_lo,
  input  wire logic [31:0] dw0_hi,
  input  wire logic [31:0] dw1_hi,
  input  wire logic [31:0] dw2_lo,
  output logic      [3:0]  endpoint_number,
  output logic      [1:0]  packet_budget,
  output logic      [10:0] max_packet_bytes,
  output logic      [14:0] transfer_byte_count,
  output logic      [14:0] bytes_left,
  output logic      [16:0] payload_cpu_addr
);
  import desc_pkg::*;

  logic [10:0] raw_max;
  logic [15:0] payload_ram_pointer;
  logic [14:0] done;

  always_comb
  begin
    endpoint_number     = {dw1_hi[EPHI_LSB +: 3], dw0_lo[EP0_BIT]};
    // Undefined multiplier treated as one packet
    packet_budget       = (dw0_lo[MULT_LSB +: 2] == 2'h0) ? 2'h1 : dw0_lo[MULT_LSB +: 2];
    raw_max             = dw0_lo[MAXPKT_LSB +: 11];
    max_packet_bytes    = (raw_max > BULK_MAX_PACKET) ? BULK_MAX_PACKET : raw_max;
    transfer_byte_count = dw0_lo[BYTECNT_LSB +: 15];
    done                = dw0_hi[DONE_LSB +: 15];
    bytes_left          = (done >= transfer_byte_count) ? 15'h0000 : transfer_byte_count - done;
    // Pointer is sixteen bits wide in both descriptor kinds
    payload_ram_pointer = dw2_lo[POINTER_LSB +: ISO_POINTER_W];
    payload_cpu_addr    = RAM_CPU_BASE + {payload_ram_pointer, 1'b0} * 17'h00004;
  end

endmodule

// ### design/usb_host_descriptor_decode.sv
// Descriptor engine: register file over AXI4-Lite plus packet issue and result handling.
// Assumes a link engine that takes packet requests and returns one result per packet.
`timescale 1ns/100ps
module usb_host_descriptor_decode
(
  input  wire logic        clock,
  input  wire logic        arst_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             pkt_valid,
  input  wire logic        pkt_ready,
  output logic [1:0]       pkt_token,
  output logic [3:0]       pkt_endpoint,
  output logic [6:0]       pkt_device,
  output logic [10:0]      pkt_length,
  output logic [16:0]      pkt_cpu_addr,
  output logic             pkt_toggle,
  input  wire logic        res_valid,
  input  wire logic [1:0]  res_code,
  input  wire logic [10:0] res_bytes
);
  import desc_pkg::*;

  typedef struct packed {
    engine_state_t state;
    logic          aw_got;
    logic [7:0]    aw_addr;
    logic          w_got;
    logic [31:0]   w_data;
    logic [3:0]    w_strb;
    logic          bvalid;
    logic          bslverr;
    logic          rvalid;
    logic          rslverr;
    logic [31:0]   rdata;
    logic [31:0]   dw0_lo;
    logic [31:0]   dw0_hi;
    logic [31:0]   dw1_hi;
    logic [31:0]   dw2_lo;
    logic [1:0]    burst_left;
    logic          fatal;
    logic [7:0]    pkt_count;
  } state_t;

  state_t st_reg;
  state_t st_next;

  logic [3:0]  endpoint_number;
  logic [1:0]  packet_budget;
  logic [10:0] max_packet_bytes;
  logic [14:0] transfer_byte_count;
  logic [14:0] bytes_left;
  logic [16:0] payload_cpu_addr;

  desc_field_decode u_decode
  (
    .dw0_lo              (st_reg.dw0_lo),
    .dw0_hi              (st_reg.dw0_hi),
    .dw1_hi              (st_reg.dw1_hi),
    .dw2_lo              (st_reg.dw2_lo),
    .endpoint_number     (endpoint_number),
    .packet_budget       (packet_budget),
    .max_packet_bytes    (max_packet_bytes),
    .transfer_byte_count (transfer_byte_count),
    .bytes_left          (bytes_left),
    .payload_cpu_addr    (payload_cpu_addr)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                        input logic [3:0] strb, input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready = !st_reg.aw_got;
  assign s_axi_wready  = !st_reg.w_got;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bslverr ? 2'h2 : 2'h0;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rslverr ? 2'h2 : 2'h0;

  assign pkt_valid    = (st_reg.state == ST_ISSUE);
  assign pkt_token    = st_reg.dw1_hi[TOKEN_LSB +: 2];
  assign pkt_endpoint = endpoint_number;
  assign pkt_device   = st_reg.dw1_hi[DEVADDR_LSB +: 7];
  assign pkt_length   = ({4'h0, max_packet_bytes} < bytes_left) ? max_packet_bytes
                                                                : bytes_left[10:0];
  assign pkt_cpu_addr = payload_cpu_addr
                      + {2'b00, st_reg.dw0_hi[DONE_LSB +: 15]};
  assign pkt_toggle   = st_reg.dw0_hi[TOGGLE_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [3:0]  nak_cnt;
    logic [3:0]  reload;
    logic [1:0]  cerr;
    logic [14:0] new_done;
    logic [31:0] word;
    nak_cnt  = st_reg.dw0_hi[NAK_RETRY_COUNTER_LSB +: 4];
    reload   = st_reg.dw2_lo[RELOAD_LSB +: 4];
    cerr     = st_reg.dw0_hi[CERR_LSB +: 2];
    new_done = st_reg.dw0_hi[DONE_LSB +: 15] + {4'h0, res_bytes};
    word     = 32'h0000_0000;
    st_next  = st_reg;

    // Register write channel
    if (s_axi_awvalid && !st_reg.aw_got)
    begin
      st_next.aw_got  = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_got)
    begin
      st_next.w_got  = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (st_reg.bvalid && s_axi_bready)
    begin
      st_next.bvalid = 1'b0;
    end

    // Read channel
    if (st_reg.rvalid && s_axi_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !st_reg.rvalid)
    begin
      st_next.rvalid  = 1'b1;
      st_next.rslverr = 1'b0;
      if (s_axi_araddr == DW0_LO_OFFSET)
        st_next.rdata = st_reg.dw0_lo;
      else if (s_axi_araddr == DW0_HI_OFFSET)
        st_next.rdata = st_reg.dw0_hi;
      else if (s_axi_araddr == DW1_HI_OFFSET)
        st_next.rdata = st_reg.dw1_hi;
      else if (s_axi_araddr == DW2_LO_OFFSET)
        st_next.rdata = st_reg.dw2_lo;
      else if (s_axi_araddr == STATUS_OFFSET)
        st_next.rdata = {22'h0, st_reg.pkt_count, st_reg.fatal, (st_reg.state != ST_IDLE)};
      else
      begin
        st_next.rdata   = 32'h0000_0000;
        st_next.rslverr = 1'b1;
      end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execution engine
    case (st_reg.state)
      ST_IDLE:
      begin
        if (st_reg.dw0_lo[VALID_BIT])
        begin
          if (bytes_left == 15'h0000)
          begin
            st_next.dw0_lo[VALID_BIT] = 1'b0;
          end
          else
          begin
            st_next.burst_left = packet_budget;
            st_next.fatal      = 1'b0;
            st_next.state      = ST_ISSUE;
          end
        end
      end
      ST_ISSUE:
      begin
        if (pkt_ready)
        begin
          st_next.pkt_count = st_reg.pkt_count + 8'h01;
          st_next.state     = ST_WAIT;
        end
      end
      ST_WAIT:
      begin
        if (res_valid)
        begin
          st_next.state = ST_IDLE;
          if (res_code == RES_ACK)
          begin
            st_next.dw0_hi[DONE_LSB +: 15] = new_done;
            st_next.dw0_hi[NAK_RETRY_COUNTER_LSB +: 4] = reload;
            st_next.dw0_hi[TOGGLE_BIT]     = !st_reg.dw0_hi[TOGGLE_BIT];
            if (new_done >= transfer_byte_count || res_bytes < max_packet_bytes)
              st_next.dw0_lo[VALID_BIT] = 1'b0;
            else if (st_reg.burst_left > 2'h1)
            begin
              st_next.burst_left = st_reg.burst_left - 2'h1;
              st_next.state      = ST_ISSUE;
            end
          end
          else if (res_code == RES_NAK)
          begin
            // A zero reload disables the NAK limit entirely
            if (reload != 4'h0)
            begin
              st_next.dw0_hi[NAK_RETRY_COUNTER_LSB +: 4] = nak_cnt - 4'h1;
              if (nak_cnt <= 4'h1)
                st_next.dw0_lo[VALID_BIT] = 1'b0;
            end
          end
          else if (res_code == RES_ERR && cerr != 2'h0)
          begin
            st_next.dw0_hi[CERR_LSB +: 2] = cerr - 2'h1;
            st_next.state                 = ST_ISSUE;
          end
          else
          begin
            st_next.fatal             = 1'b1;
            st_next.dw0_lo[VALID_BIT] = 1'b0;
          end
        end
      end
      default:
      begin
        st_next.state = ST_IDLE;
      end
    endcase

    // Software write last, so a write landing with a hardware update wins
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid)
    begin
      st_next.aw_got  = 1'b0;
      st_next.w_got   = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bslverr = 1'b0;
      if (st_reg.aw_addr == DW0_LO_OFFSET)
        st_next.dw0_lo = merge(st_reg.dw0_lo, st_reg.w_data, st_reg.w_strb, DW0_LO_MASK);
      else if (st_reg.aw_addr == DW0_HI_OFFSET)
        st_next.dw0_hi = merge(st_reg.dw0_hi, st_reg.w_data, st_reg.w_strb, DW0_HI_MASK);
      else if (st_reg.aw_addr == DW1_HI_OFFSET)
      begin
        word = merge(st_reg.dw1_hi, st_reg.w_data, st_reg.w_strb, DW1_HI_MASK);
        // PING belongs to the controller; software cannot select it
        if (word[TOKEN_LSB +: 2] == TOKEN_PING)
          word[TOKEN_LSB +: 2] = st_reg.dw1_hi[TOKEN_LSB +: 2];
        st_next.dw1_hi = word;
      end
      else if (st_reg.aw_addr == DW2_LO_OFFSET)
        st_next.dw2_lo = merge(st_reg.dw2_lo, st_reg.w_data, st_reg.w_strb, DW2_LO_MASK);
      else if (st_reg.aw_addr != STATUS_OFFSET)
        st_next.bslverr = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '{state: ST_IDLE, default: '0};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

endmodule

// ### testbench/usb_link_model.sv
// Link partner model: takes packet requests and answers each with one result.
// Assumes the bench sets reply code and lag before arming a descriptor.
`timescale 1ns/100ps
module usb_link_model
(
  input  wire logic        clock,
  input  wire logic        pkt_valid,
  input  wire logic [10:0] pkt_length,
  input  wire logic [1:0]  reply_code,
  input  wire logic [3:0]  reply_lag,
  output logic             pkt_ready,
  output logic             res_valid,
  output logic [1:0]       res_code,
  output logic [10:0]      res_bytes,
  output logic [7:0]       pkt_count
);
  logic        busy = 1'b0;
  logic [3:0]  lag  = 4'h0;
  logic [10:0] len  = 11'h000;
  initial
  begin
    pkt_ready = 1'b0;
    res_valid = 1'b0;
    res_code  = 2'h0;
    res_bytes = 11'h000;
    pkt_count = 8'h00;
  end
  ////////////////////////////////////////
  // Result lines flip while idle, so a stale value never passes for a reply
  always @(posedge clock)
  begin
    res_valid <= 1'b0;
    res_code  <= ~res_code;
    res_bytes <= ~res_bytes;
    pkt_ready <= pkt_valid && !busy && !pkt_ready;
    if (pkt_valid && pkt_ready)
    begin
      busy      <= 1'b1;
      lag       <= reply_lag;
      len       <= pkt_length;
      pkt_count <= pkt_count + 8'h01;
    end
    else if (busy && lag != 4'h0)
      lag <= lag - 4'h1;
    else if (busy)
    begin
      busy      <= 1'b0;
      res_valid <= 1'b1;
      res_code  <= reply_code;
      res_bytes <= len;
    end
  end
endmodule

// ### testbench/usb_desc_chk.sv
// Port checker for the descriptor engine: handshakes and packet requests.
// Assumes a bind onto the top module; sees its ports only.
`timescale 1ns/100ps
module usb_desc_chk
(
  input wire logic        clock,
  input wire logic        arst_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        pkt_valid,
  input wire logic        pkt_ready,
  input wire logic [10:0] pkt_length,
  input wire logic [16:0] pkt_cpu_addr,
  input wire logic        res_valid,
  input wire logic [1:0]  res_code
);
  import desc_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////
  property p_len; pkt_valid |-> pkt_length <= BULK_MAX_PACKET && pkt_length != 11'h000;
  endproperty
  a_len: assert property (p_len) else $error("packet length out of range");
  property p_addr; pkt_valid |-> pkt_cpu_addr >= RAM_CPU_BASE; endproperty
  a_addr: assert property (p_addr) else $error("payload address below base");
  property p_wait; pkt_valid && pkt_ready |=> !pkt_valid; endproperty
  a_wait: assert property (p_wait) else $error("packet issued before result");
  property p_hold; pkt_valid && !pkt_ready |=> pkt_valid && $stable(pkt_length)
    && $stable(pkt_cpu_addr); endproperty
  a_hold: assert property (p_hold) else $error("packet request changed while waiting");
  property p_fatal; res_valid && res_code == RES_FATAL |=> !pkt_valid [*4]; endproperty
  a_fatal: assert property (p_fatal) else $error("packet after fatal result");
  property p_nak; res_valid && res_code == RES_NAK |=> !pkt_valid; endproperty
  a_nak: assert property (p_nak) else $error("packet right after refusal");
  property p_bresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("read data late");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data not held");
  c_pkt: cover property (pkt_valid && pkt_ready);
  c_fatal: cover property (res_valid && res_code == RES_FATAL);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind usb_host_descriptor_decode usb_desc_chk i_chk (.clock, .arst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pkt_valid, .pkt_ready,
  .pkt_length, .pkt_cpu_addr, .res_valid, .res_code);

// ### testbench/test_usb_host_descriptor_decode.sv
// Bench for the descriptor engine: register access and descriptor runs.
// Assumes the link model answers every packet request.
`timescale 1ns/100ps
module test_usb_host_descriptor_decode;
  logic        clock = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, pkt_token, res_code;
  logic [31:0] s_axi_rdata;
  logic        pkt_valid, pkt_ready, res_valid;
  logic [3:0]  pkt_endpoint, last_ep;
  logic [10:0] pkt_length, res_bytes, last_len;
  logic [16:0] pkt_cpu_addr, last_addr;
  logic [1:0]  reply_code = 2'h0, last_tok;
  logic [3:0]  reply_lag = 4'h0;
  logic [7:0]  pkt_count;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [6:0]  pkt_device, last_dev;
  logic        pkt_toggle, last_tgl;
  int          mismatches = 0;
  int          num_checks = 0;
  always #25 clock = ~clock;
  usb_host_descriptor_decode i_dut (.clock, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pkt_valid,
    .pkt_ready, .pkt_token, .pkt_endpoint, .pkt_device, .pkt_length, .pkt_cpu_addr,
    .pkt_toggle, .res_valid, .res_code, .res_bytes);
  usb_link_model i_link (.clock, .pkt_valid, .pkt_length, .reply_code, .reply_lag,
    .pkt_ready, .res_valid, .res_code, .res_bytes, .pkt_count);
  always @(posedge clock)
    if (pkt_valid && pkt_ready)
    begin
      last_addr <= pkt_cpu_addr;
      last_len  <= pkt_length;
      last_tok  <= pkt_token;
      last_ep   <= pkt_endpoint;
      last_dev  <= pkt_device;
      last_tgl  <= pkt_toggle;
    end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(r));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clock);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask
  // Arms one descriptor, polls until the engine drops its valid flag, then checks
  task automatic run(input logic [31:0] lo, hi, d2, input logic [1:0] code, tok,
    input logic [3:0] lag, input logic [7:0] npk, input logic [31:0] ehi, input logic fat);
    logic [7:0]  c0;
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    reply_code <= code;
    reply_lag  <= lag;
    c0 = pkt_count;
    wr(8'h04, hi, 2'h0);
    wr(8'h0C, d2, 2'h0);
    wr(8'h08, 32'h2155 | {tok, 10'h000}, 2'h0);
    wr(8'h00, lo, 2'h0);
    d = 32'h1;
    for (n = 0; n < 60 && d[0] !== 1'b0; n++)
      rd(8'h00, d, r);
    chk(32'(d[0]), 32'h0);
    chk(32'(pkt_count - c0), 32'(npk));
    rc(8'h04, ehi, 2'h0);
    rd(8'h10, d, r);
    chk(32'(d[1]), 32'(fat));
    if (npk != 8'h00)
    begin
      chk(32'(last_tok), 32'(tok));
      chk(32'(last_ep), {28'h0, 3'h5, lo[31]});
      chk(32'(last_dev), 32'h2A);
    end
    $display("test run with code %0d done", code);
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    logic [31:0] ones [4];
    ones = '{32'hFFFF_FFF8, 32'h03F8_7FFE, 32'h0000_73FE, 32'h1EFF_FF00};
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
      rc(8'(i * 4), 32'h0, (i < 5) ? 2'h0 : 2'h2);
    wr(8'h20, 32'hFFFF_FFFF, 2'h2);
    wr(8'h10, 32'hFFFF_FFFF, 2'h0);
    rc(8'h10, 32'h0, 2'h0);
    $display("test reset and map done");
    for (int i = 0; i < 4; i++)
    begin
      wr(8'(i * 4), 32'hFFFF_FFFE, 2'h0);
      rc(8'(i * 4), ones[i], 2'h0);
    end
    // Only byte 1 of the pointer word is written
    s_axi_wstrb <= 4'h2;
    wr(8'h0C, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    rc(8'h0C, 32'h1EFF_0000, 2'h0);
    $display("test field layout done");
    run(32'hC020_00A1, 32'h0, 32'h100, 2'h0, 2'h0, 4'h0, 8'h03, 32'h0200_0014, 1'b0);
    chk(32'(last_addr), 32'h418);
    chk(32'(last_tgl), 32'h0);
    chk(32'(last_len), 32'h4);
    run(32'h2FFC_12C1, 32'h0, 32'h100, 2'h0, 2'h1, 4'h6, 8'h02, 32'h258, 1'b0);
    chk(32'(last_addr), 32'h608);
    chk(32'(last_len), 32'h58);
    chk(32'(last_tgl), 32'h1);
    run(32'h2020_0041, 32'h0010_0000, 32'h0400_0100, 2'h1, 2'h2, 4'h2, 8'h02, 32'h0, 1'b0);
    run(32'h2020_0001, 32'h0, 32'h100, 2'h0, 2'h0, 4'h0, 8'h00, 32'h0, 1'b0);
    run(32'h2020_0041, 32'h0, 32'h100, 2'h3, 2'h1, 4'h3, 8'h01, 32'h0, 1'b1);
    run(32'h2020_0041, 32'h0080_0000, 32'h100, 2'h2, 2'h2, 4'h1, 8'h02, 32'h0, 1'b1);
    final_report;
  end
  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    final_report;
  end
endmodule
